// ==== include/sram_host_consts.svh ====
// Timing constants and bus widths for the static memory host controller.
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS              25
`define READ_CYCLE_MIN_NS          100
`define WRITE_CYCLE_MIN_NS         100
`define WRITE_PULSE_MIN_NS         80
`define SELECT_WRITE_OVERLAP_MIN_NS 90
`define WRITE_DATA_SETUP_NS        50
`define ADDRESS_TO_DATA_DELAY_NS   100
`define OUTPUT_ENABLE_TO_DATA_DELAY_NS 50
`define OE_RELEASE_MAX_NS          30
`define RETENTION_SELECT_HOLD_NS   100
`define CEIL_CYCLES(ns)            (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W                     15
`define DATA_W                     8
`endif

// ==== include/sram_host_pkg.sv ====
// Types shared by the static memory host controller.
`default_nettype none
package sram_host_pkg;
    typedef struct packed {
        logic        write;
        logic [14:0] address;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic select_n;
        logic output_enable_n;
        logic write_n;
    } strobes_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_READ   = 3'b001,
        ST_RDONE  = 3'b011,
        ST_WRITE  = 3'b010,
        ST_WDONE  = 3'b110,
        ST_RETAIN = 3'b100,
        ST_WAKE   = 3'b101
    } host_state_t;
endpackage
`default_nettype wire

// ==== src/sram_cycle_timer.sv ====
// Down counter that times each phase of a memory cycle.
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_timer #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count;

    if (WIDTH < 2) begin : g_bad_width
        $error("sram_cycle_timer: WIDTH must be at least 2");
    end

    assign done = (count == '0);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
        end else if (clk_en) begin
            if (load) begin
                count <= load_value;
            end else if (!done) begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // sram_cycle_timer
`default_nettype wire

// ==== src/sram_host_ctrl.sv ====
// Host controller that runs read and write cycles on an asynchronous 32K x 8 memory.
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_consts.svh"
module sram_host_ctrl #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clk_en,
    input  wire logic                    req_valid,
    input  wire sram_host_pkg::mem_req_t req,
    output logic                         req_ready,
    output logic                         rdata_valid,
    output logic [DATA_W-1:0]            rdata,
    input  wire logic                    retain_req,
    output logic                         retain_ok,
    output logic [ADDR_W-1:0]            word_address,
    output sram_host_pkg::strobes_t      strobes,
    input  wire logic [DATA_W-1:0]       data_bus_in,
    output logic [DATA_W-1:0]            data_bus_out,
    output logic                         data_bus_oe
);
    import sram_host_pkg::*;

    // ----------------------------------------------------------------
    // Timing counts
    // ----------------------------------------------------------------
    // The read phase covers address access; the memory must also have
    // released the bus (max 30 ns) before the host drives it, so two
    // extra cycles of turnaround follow every read.
    localparam logic [3:0] READ_CYC  = 4'(`CEIL_CYCLES(`READ_CYCLE_MIN_NS));
    localparam logic [3:0] WRITE_CYC = 4'(`CEIL_CYCLES(`SELECT_WRITE_OVERLAP_MIN_NS));
    localparam logic [3:0] REST_CYC  = 4'(`CEIL_CYCLES(`WRITE_CYCLE_MIN_NS
                                          - `SELECT_WRITE_OVERLAP_MIN_NS));
    localparam logic [3:0] TURN_CYC  = 4'(`CEIL_CYCLES(`OE_RELEASE_MAX_NS));
    localparam logic [3:0] WAKE_CYC  = 4'(`CEIL_CYCLES(`RETENTION_SELECT_HOLD_NS));

    if (ADDR_W != 15 || DATA_W != 8) begin : g_bad_width
        $error("sram_host_ctrl: bus widths fixed at 15/8");
    end

    // ----------------------------------------------------------------
    // State and timer
    // ----------------------------------------------------------------
    host_state_t state;
    host_state_t next_state;
    logic        timer_load;
    logic [3:0]  timer_value;
    logic        timer_done;
    logic [DATA_W-1:0] bus_in_meta;
    logic [DATA_W-1:0] bus_in_sync;

    sram_cycle_timer #(.WIDTH(4)) u_timer (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    wire take_req   = (state == ST_IDLE) && req_valid && !retain_req;
    wire take_ret   = (state == ST_IDLE) && retain_req;

    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = 4'h0;
        unique case (state)
            ST_IDLE: begin
                if (take_ret) begin
                    next_state = ST_RETAIN;
                end else if (take_req) begin
                    next_state  = req.write ? ST_WRITE : ST_READ;
                    timer_load  = 1'b1;
                    timer_value = req.write ? WRITE_CYC - 4'h1 : READ_CYC + 4'h1;
                end
            end
            ST_READ: begin
                if (timer_done) begin
                    next_state  = ST_RDONE;
                    timer_load  = 1'b1;
                    timer_value = TURN_CYC - 4'h1;
                end
            end
            ST_RDONE: if (timer_done) next_state = ST_IDLE;
            ST_WRITE: begin
                if (timer_done) begin
                    next_state  = ST_WDONE;
                    timer_load  = 1'b1;
                    timer_value = REST_CYC;
                end
            end
            ST_WDONE: if (timer_done) next_state = ST_IDLE;
            ST_RETAIN: begin
                if (!retain_req) begin
                    next_state  = ST_WAKE;
                    timer_load  = 1'b1;
                    timer_value = WAKE_CYC - 4'h1;
                end
            end
            ST_WAKE: if (timer_done) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    wire next_sel_n = !(next_state == ST_READ || next_state == ST_WRITE);
    wire next_oe_n  = (next_state != ST_READ);
    wire next_we_n  = (next_state != ST_WRITE);
    wire next_drive = (next_state == ST_WRITE);
    wire read_take  = (state == ST_RDONE) && !timer_done;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobes     <= '{select_n: 1'b1, output_enable_n: 1'b1, write_n: 1'b1};
            data_bus_oe <= 1'b0;
        end else if (clk_en) begin
            strobes     <= '{select_n: next_sel_n, output_enable_n: next_oe_n,
                             write_n: next_we_n};
            data_bus_oe <= next_drive;
        end
    end

    // Address and data only move when a new cycle is taken, so they are
    // stable from the strobe fall to the strobe rise.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_address <= 15'h0000;
            data_bus_out <= 8'h00;
        end else if (clk_en && take_req) begin
            word_address <= req.address;
            data_bus_out <= req.wdata;
        end
    end

    // Read data is taken in the first turnaround cycle, from the sample made
    // 125 ns after the address moved, so the access time has a full margin.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_in_meta <= 8'h00;
            bus_in_sync <= 8'h00;
        end else if (clk_en) begin
            bus_in_meta <= data_bus_in;
            bus_in_sync <= bus_in_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
            req_ready   <= 1'b0;
            retain_ok   <= 1'b0;
        end else if (clk_en) begin
            rdata_valid <= read_take;
            if (read_take) begin
                rdata <= bus_in_sync;
            end
            req_ready <= (next_state == ST_IDLE) && !retain_req;
            retain_ok <= (next_state == ST_RETAIN);
        end else begin
            rdata_valid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !clk_en);

    sequence s_write_start;
        $fell(strobes.write_n);
    endsequence

    AST_READ_WE_HIGH: assert property (!strobes.output_enable_n |-> strobes.write_n)
        else $error("write strobe low during read");
    AST_NO_CONTENTION: assert property (data_bus_oe |-> strobes.output_enable_n)
        else $error("host drives bus while memory enabled");
    AST_READ_LEN: assert property (
        $fell(strobes.output_enable_n) |-> !strobes.output_enable_n [*6])
        else $error("read cycle too short");
    AST_WRITE_PULSE: assert property (
        s_write_start |-> (!strobes.write_n && !strobes.select_n) [*4])
        else $error("write pulse too short");
    AST_DATA_STABLE: assert property (
        !strobes.write_n
        |-> data_bus_oe && ($past(strobes.write_n) || $stable(data_bus_out)))
        else $error("write data changed in pulse");
    AST_ADDR_STABLE: assert property (
        !strobes.select_n && !$past(strobes.select_n) |-> $stable(word_address))
        else $error("address moved in a cycle");
    AST_WRITE_SPACING: assert property (
        $rose(strobes.write_n) |-> strobes.write_n [*3])
        else $error("writes back to back");
    AST_OE_CONST: assert property (!strobes.write_n |-> strobes.output_enable_n)
        else $error("output enable moved in write");
    AST_RETAIN_SEL: assert property (retain_ok |-> strobes.select_n)
        else $error("select low in retention");
endmodule // sram_host_ctrl
`default_nettype wire

// ==== testbench/sram_mem_model.sv ====
// Behavioural model of the asynchronous 32K x 8 static memory.
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model (
    input  wire logic [14:0]             word_address,
    input  wire sram_host_pkg::strobes_t strobes,
    input  wire logic [7:0]              host_data,
    input  wire logic                    host_oe,
    output logic [7:0]                   data_bus_in
);
    import sram_host_pkg::*;
    // ----------------------------------------
    // Storage and pin behaviour
    // ----------------------------------------
    logic [7:0]  mem [0:32767];
    logic [7:0]  q    = 8'hA5;
    logic [7:0]  last = 8'h3C;
    logic [14:0] wa;
    logic [7:0]  wd;
    realtime     t0   = 0;
    wire drive  = !strobes.select_n && !strobes.output_enable_n && strobes.write_n;
    wire wr_act = !strobes.select_n && !strobes.write_n;
    // Access time restarts on every address change or output turn-on.
    always @(word_address or drive) t0 = $realtime;
    // A 1 ns poll avoids racing the host's same-edge address change.
    always #1 begin
        if (wr_act) begin
            wa = word_address;
            wd = host_oe ? host_data : ~last;
        end
        if (drive && ($realtime - t0 >= 100.0)) begin
            q = mem[word_address];
            last = q;
        end else begin
            q = ~q;
        end
    end
    always @(negedge wr_act) mem[wa] = wd;
    // Floating pins show the inverse of the last level, never a kind default.
    assign data_bus_in = (host_oe && drive) ? 8'hXX : host_oe ? host_data :
                         drive ? q : ~last;
endmodule // sram_mem_model
`default_nettype wire

// ==== testbench/sram_host_ctrl_tb.sv ====
// Self-checking testbench for the static memory host controller.
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_tb;
    import sram_host_pkg::*;
    // ----------------------------------------
    // Signals, clock and checking
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        req_valid = 1'b0;
    mem_req_t    req = '0;
    logic        retain_req = 1'b0;
    logic        req_ready, rdata_valid, retain_ok, data_bus_oe;
    logic [7:0]  rdata, data_bus_in, data_bus_out, wdat;
    logic [14:0] word_address;
    strobes_t    strobes;
    int          fails = 0;
    int          samples_checked = 0;
    int          wlow = 0;
    bit          sel_was = 0;
    realtime     t_sel = 0;
    sram_host_ctrl dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rdata_valid(rdata_valid), .rdata(rdata), .retain_req(retain_req),
        .retain_ok(retain_ok), .word_address(word_address), .strobes(strobes),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
    sram_mem_model mem_model (.word_address(word_address), .strobes(strobes),
        .host_data(data_bus_out), .host_oe(data_bus_oe), .data_bus_in(data_bus_in));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Registered outputs are settled at the falling edge.
    always @(negedge clk) begin
        if (!sys_rst) begin
            if (!strobes.output_enable_n) begin
                check(strobes.write_n, 1, "write strobe low in read");
                check(data_bus_oe, 0, "host drives during read");
            end
            if (!strobes.write_n) begin
                check(strobes.output_enable_n, 1, "oe moved in write");
                check(data_bus_oe, 1, "write data not driven");
                if (wlow > 0) check(data_bus_out, wdat, "write data moved");
                wlow++;
                wdat = data_bus_out;
            end else if (wlow > 0) begin
                check(wlow >= 4, 1, "write pulse short");
                wlow = 0;
            end
            if (!strobes.select_n && !sel_was) begin
                if (t_sel > 0) check($realtime - t_sel >= 100.0, 1, "cycle spacing");
                t_sel = $realtime;
            end
            sel_was = !strobes.select_n;
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        check(n < 40, 1, "ready timeout");
    endtask
    task automatic read_back(input logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdata_valid !== 1'b1 && n < 20);
        check(n < 20, 1, "read answer timeout");
        check(rdata, d, "read data");
    endtask
    task automatic do_op(input logic w, input logic [14:0] a, input logic [7:0] d);
        wait_ready();
        req_valid <= 1'b1;
        req <= {w, a, d};
        @(posedge clk);
        req_valid <= 1'b0;
        if (!w) read_back(d);
    endtask
    // Boundary addresses and patterns, written then read back to back.
    task automatic test_write_read();
        logic [14:0] ta [4] = '{15'h0000, 15'h7FFF, 15'h1555, 15'h2AAA};
        logic [7:0]  td [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
        for (int i = 0; i < 4; i++) do_op(1'b1, ta[i], td[i]);
        for (int i = 0; i < 4; i++) do_op(1'b0, ta[i], td[i]);
    endtask
    // A second request during a busy write is ignored.
    task automatic test_busy();
        do_op(1'b1, 15'h0010, 8'h11);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {1'b1, 15'h0010, 8'h22};
        @(posedge clk);
        req_valid <= 1'b0;
        do_op(1'b0, 15'h0010, 8'h11);
    endtask
    task automatic test_retain();
        wait_ready();
        retain_req <= 1'b1;
        repeat (2) @(posedge clk);
        check(retain_ok, 1, "retention not entered");
        check(strobes.select_n, 1, "select low in retention");
        check(req_ready, 0, "ready in retention");
        repeat (3) @(posedge clk);
        retain_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            check(strobes.select_n, 1, "select low after recovery");
        end
        do_op(1'b0, 15'h7FFF, 8'hFF);
    endtask
    // Clock enable low in mid-read freezes the strobes; the read still completes.
    task automatic test_freeze();
        do_op(1'b1, 15'h0020, 8'h3C);
        wait_ready();
        req_valid <= 1'b1;
        req <= {1'b0, 15'h0020, 8'h00};
        @(posedge clk);
        req_valid <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        check(strobes, 3'b001, "strobes moved while frozen");
        check(req_ready, 0, "ready while frozen");
        clk_en <= 1'b1;
        read_back(8'h3C);
    endtask
    initial begin
        repeat (19) @(posedge clk);
        check(strobes, 3'b111, "strobes in reset");
        check(data_bus_oe, 0, "bus driven in reset");
        @(posedge clk);
        sys_rst <= 1'b0;
        test_write_read();
        test_busy();
        test_retain();
        test_freeze();
        close_out();
    end
    initial begin
        #(5000 * 25);
        fails++;
        close_out();
    end
endmodule // sram_host_ctrl_tb
`default_nettype wire
